// ---- src/sleep_mask_pkg.sv ----
// constants for the sleep-state error mask bank
package sleep_mask_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int INPUT_N = 8;
    localparam int FAN_N = 4;
    localparam logic [ADDR_W-1:0] S1_INPUT_OFS = 8'h00e5;
    localparam logic [ADDR_W-1:0] S1_FAN_OFS = 8'h00e6;
    localparam logic [ADDR_W-1:0] S3_INPUT_OFS = 8'h00e7;
    localparam logic [ADDR_W-1:0] S3_FAN_OFS = 8'h00e8;
    localparam logic [INPUT_N-1:0] INPUT_MASK_RST = 8'h00ff;
    localparam logic [FAN_N-1:0] FAN_MASK_RST = 4'h000f;
    typedef enum logic [1:0] {
        SLEEP_S0,
        SLEEP_S1,
        SLEEP_S3,
        SLEEP_S45
    } sleep_state_t;
endpackage

// ---- src/mask_select.sv ----
// selects the active mask set from the sleep state
`timescale 1ns/1ps
`default_nettype none
module mask_select
    import sleep_mask_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire sleep_mask_pkg::sleep_state_t state,
    input wire logic [WIDTH-1:0] s1_mask,
    input wire logic [WIDTH-1:0] s3_mask,
    input wire logic [WIDTH-1:0] s45_mask,
    output logic [WIDTH-1:0] active_mask
);
    always_comb begin
        case (state)
            SLEEP_S1: active_mask = s1_mask;
            SLEEP_S3: active_mask = s3_mask;
            SLEEP_S45: active_mask = s45_mask;
            default: active_mask = '0;
        endcase
    end
endmodule
`default_nettype wire

// ---- src/sleep_state_error_masks.sv ----
// sleep-state error mask registers and event gating
`timescale 1ns/1ps
`default_nettype none
module sleep_state_error_masks #(
    parameter int INPUTS = sleep_mask_pkg::INPUT_N,
    parameter int FANS = sleep_mask_pkg::FAN_N
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [sleep_mask_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sleep_mask_pkg::DATA_W-1:0] reg_wdata,
    output logic [sleep_mask_pkg::DATA_W-1:0] reg_rdata,
    input wire sleep_mask_pkg::sleep_state_t sleep_state_select,
    input wire logic [INPUTS-1:0] s45_input_mask,
    input wire logic [INPUTS-1:0] input_error,
    input wire logic [FANS-1:0] fan_error,
    output logic [INPUTS-1:0] input_error_out,
    output logic [FANS-1:0] fan_error_out
);
    import sleep_mask_pkg::*;

    function automatic logic hits(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction

    logic [INPUTS-1:0] s1_input_q;
    logic [INPUTS-1:0] s3_input_q;
    logic [FANS-1:0] s1_fan_q;
    logic [FANS-1:0] s3_fan_q;
    logic [INPUTS-1:0] input_wdata;
    logic [FANS-1:0] fan_wdata;
    logic [DATA_W-1:0] reg_rdata_d;
    logic [INPUTS-1:0] input_active;
    logic [FANS-1:0] fan_active;
    logic [INPUTS-1:0] input_error_d;
    logic [FANS-1:0] fan_error_d;
    sleep_state_t state_eff;

    // register decode
    wire logic wr_s1_in = reg_wr && hits(reg_addr, S1_INPUT_OFS);
    wire logic wr_s1_fan = reg_wr && hits(reg_addr, S1_FAN_OFS);
    wire logic wr_s3_in = reg_wr && hits(reg_addr, S3_INPUT_OFS);
    wire logic wr_s3_fan = reg_wr && hits(reg_addr, S3_FAN_OFS);
    wire logic rd_s1_in = reg_rd && hits(reg_addr, S1_INPUT_OFS);
    wire logic rd_s1_fan = reg_rd && hits(reg_addr, S1_FAN_OFS);
    wire logic rd_s3_in = reg_rd && hits(reg_addr, S3_INPUT_OFS);
    wire logic rd_s3_fan = reg_rd && hits(reg_addr, S3_FAN_OFS);

    // write data, fan upper bits dropped
    assign input_wdata = reg_wdata[INPUTS-1:0];
    assign fan_wdata = reg_wdata[FANS-1:0];

    // read data mux, unmapped reads zero
    assign reg_rdata_d = ({DATA_W{rd_s1_in}} & DATA_W'(s1_input_q))
        | ({DATA_W{rd_s1_fan}} & DATA_W'(s1_fan_q))
        | ({DATA_W{rd_s3_in}} & DATA_W'(s3_input_q))
        | ({DATA_W{rd_s3_fan}} & DATA_W'(s3_fan_q));

    assign state_eff = rst ? SLEEP_S45 : sleep_state_select;

    // per-bit event gating
    for (genvar gi = 0; gi < INPUTS; gi++) begin : g_input_gate
        assign input_error_d[gi] = input_error[gi] & ~input_active[gi];
    end

    for (genvar gf = 0; gf < FANS; gf++) begin : g_fan_gate
        assign fan_error_d[gf] = fan_error[gf] & ~fan_active[gf];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_input_q <= INPUTS'(INPUT_MASK_RST);
        end else if (wr_s1_in) begin
            s1_input_q <= input_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s3_input_q <= INPUTS'(INPUT_MASK_RST);
        end else if (wr_s3_in) begin
            s3_input_q <= input_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_fan_q <= FANS'(FAN_MASK_RST);
        end else if (wr_s1_fan) begin
            s1_fan_q <= fan_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s3_fan_q <= FANS'(FAN_MASK_RST);
        end else if (wr_s3_fan) begin
            s3_fan_q <= fan_wdata;
        end
    end

    mask_select #(.WIDTH(INPUTS)) input_sel (
        .state(state_eff),
        .s1_mask(s1_input_q),
        .s3_mask(s3_input_q),
        .s45_mask(s45_input_mask),
        .active_mask(input_active)
    );

    mask_select #(.WIDTH(FANS)) fan_sel (
        .state(state_eff),
        .s1_mask(s1_fan_q),
        .s3_mask(s3_fan_q),
        .s45_mask('0),
        .active_mask(fan_active)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
            input_error_out <= '0;
            fan_error_out <= '0;
        end else begin
            reg_rdata <= reg_rdata_d;
            input_error_out <= input_error_d;
            fan_error_out <= fan_error_d;
        end
    end

    // checks
    s1_input_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        (sleep_state_select == SLEEP_S1) |=>
        (input_error_out == ($past(input_error) & ~$past(s1_input_q))))
        else $error("s1 input masking wrong");

    s1_fan_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        (sleep_state_select == SLEEP_S1) |=>
        (fan_error_out == ($past(fan_error) & ~$past(s1_fan_q))))
        else $error("s1 fan masking wrong");

    s3_input_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        (sleep_state_select == SLEEP_S3) |=>
        (input_error_out == ($past(input_error) & ~$past(s3_input_q))))
        else $error("s3 input masking wrong");

    s3_fan_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        (sleep_state_select == SLEEP_S3) |=>
        (fan_error_out == ($past(fan_error) & ~$past(s3_fan_q))))
        else $error("s3 fan masking wrong");

    s0_no_mask_a: assert property (@(posedge core_clk) disable iff (rst)
        (sleep_state_select == SLEEP_S0) |=> (input_error_out == $past(input_error)))
        else $error("s0 must not mask");

    s0_fan_pass_a: assert property (@(posedge core_clk) disable iff (rst)
        (sleep_state_select == SLEEP_S0) |=>
        (fan_error_out == $past(fan_error)))
        else $error("s0 must not mask fans");

    s45_input_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        (sleep_state_select == SLEEP_S45) |=>
        (input_error_out == ($past(input_error) & ~$past(s45_input_mask))))
        else $error("s45 input masking wrong");

    s45_fan_pass_a: assert property (@(posedge core_clk) disable iff (rst)
        (sleep_state_select == SLEEP_S45) |=>
        (fan_error_out == $past(fan_error)))
        else $error("s45 fan events wrong");

    reset_state_a: assert property (@(posedge core_clk)
        rst |-> (state_eff == SLEEP_S45))
        else $error("reset must select s45");

    reset_quiet_a: assert property (@(posedge core_clk)
        rst ##1 rst |-> (input_error_out == '0) && (fan_error_out == '0))
        else $error("events leak during reset");

    reset_load_a: assert property (@(posedge core_clk)
        $fell(rst) |->
        (s1_input_q == INPUTS'(INPUT_MASK_RST)) && (s3_input_q == INPUTS'(INPUT_MASK_RST)) &&
        (s1_fan_q == FANS'(FAN_MASK_RST)) && (s3_fan_q == FANS'(FAN_MASK_RST)))
        else $error("mask reset values wrong");

    fan_rsvd_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == S1_FAN_OFS) |=> (reg_rdata[DATA_W-1:FANS] == '0))
        else $error("reserved bits nonzero");

    s3_rsvd_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == S3_FAN_OFS) |=> (reg_rdata[DATA_W-1:FANS] == '0))
        else $error("s3 reserved bits nonzero");

    write_back_a: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == S1_INPUT_OFS) ##1
        (reg_rd && !reg_wr && reg_addr == S1_INPUT_OFS)
        |=> (reg_rdata == $past(reg_wdata, 2)))
        else $error("s1 input mask readback wrong");

    s3_in_back_a: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == S3_INPUT_OFS) ##1
        (reg_rd && !reg_wr && reg_addr == S3_INPUT_OFS)
        |=> (reg_rdata == $past(reg_wdata, 2)))
        else $error("s3 input mask readback wrong");

    s1_fan_back_a: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == S1_FAN_OFS) ##1
        (reg_rd && !reg_wr && reg_addr == S1_FAN_OFS)
        |=> (reg_rdata == DATA_W'($past(reg_wdata[FANS-1:0], 2))))
        else $error("s1 fan mask readback wrong");

    s3_fan_back_a: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == S3_FAN_OFS) ##1
        (reg_rd && !reg_wr && reg_addr == S3_FAN_OFS)
        |=> (reg_rdata == DATA_W'($past(reg_wdata[FANS-1:0], 2))))
        else $error("s3 fan mask readback wrong");

    s1_cov: cover property (@(posedge core_clk) sleep_state_select == SLEEP_S1 && |input_error);
    s3_cov: cover property (@(posedge core_clk) sleep_state_select == SLEEP_S3 && |fan_error);
    wr_cov: cover property (@(posedge core_clk) wr_s3_fan);
    s45_cov: cover property (@(posedge core_clk) sleep_state_select == SLEEP_S45 && |input_error);
    rd_cov: cover property (@(posedge core_clk) rd_s3_fan);
endmodule
`default_nettype wire

// ---- verif/tb_sleep_state_error_masks.sv ----
// self-checking bench for the sleep-state error mask bank
`timescale 1ns/1ps
`default_nettype none
module tb_sleep_state_error_masks;
    import sleep_mask_pkg::*;
    typedef struct {int due; int kind; logic [7:0] exp;} note_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    sleep_state_t sleep_state_select = SLEEP_S0;
    logic [7:0] s45_input_mask = 8'h00;
    logic [7:0] input_error = 8'h00;
    logic [3:0] fan_error = 4'h0;
    logic [7:0] input_error_out;
    logic [3:0] fan_error_out;
    logic [7:0] shadow [4] = '{8'hff, 8'h0f, 8'hff, 8'h0f};
    logic [7:0] got;
    string nm [3] = '{"reg_rdata", "input_error_out", "fan_error_out"};
    note_t notes [$];
    note_t n;
    int cyc = 0;
    int bad_count = 0;
    int checked = 0;
    sleep_state_error_masks dut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sleep_state_select(sleep_state_select), .s45_input_mask(s45_input_mask),
        .input_error(input_error), .fan_error(fan_error), .input_error_out(input_error_out),
        .fan_error_out(fan_error_out));
    always #25 core_clk = ~core_clk;
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc > 1000) begin
            bad_count++;
            final_report();
        end
    end
    // watcher: results due this cycle
    always @(negedge core_clk) begin
        while (notes.size() > 0 && notes[0].due == cyc) begin
            n = notes.pop_front();
            got = (n.kind == 0) ? reg_rdata : (n.kind == 1) ? input_error_out : {4'h0, fan_error_out};
            checked++;
            if (got !== n.exp) begin
                bad_count++;
                $display("unexpected %s exp %h got %h", nm[n.kind], n.exp, got);
            end
        end
    end
    task automatic drive(bit w, bit r, logic [7:0] a, logic [7:0] d, logic [7:0] ie, logic [3:0] fe);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        input_error <= ie;
        fan_error <= fe;
    endtask
    task automatic put(int k, logic [7:0] e);
        notes.push_back('{cyc + 2, k, e});
    endtask
    task automatic wr(int i, logic [7:0] d);
        drive(1, 0, 8'he5 + i[7:0], d, 8'h00, 4'h0);
        shadow[i] = i[0] ? (d & 8'h0f) : d;
    endtask
    task automatic rd_all();
        for (int a = 8'he4; a <= 8'he9; a++) begin
            drive(0, 1, a[7:0], 8'h00, 8'h00, 4'h0);
            put(0, (a > 8'he4 && a < 8'he9) ? shadow[a - 8'he5] : 8'h00);
        end
    endtask
    task automatic ev(logic [7:0] ie, logic [3:0] fe);
        logic [11:0] m;
        case (sleep_state_select)
            SLEEP_S1: m = {shadow[1][3:0], shadow[0]};
            SLEEP_S3: m = {shadow[3][3:0], shadow[2]};
            SLEEP_S45: m = {4'h0, s45_input_mask};
            default: m = 12'h000;
        endcase
        drive(0, 0, 8'h00, 8'h00, ie, fe);
        put(1, ie & ~m[7:0]);
        put(2, {4'h0, fe & ~m[11:8]});
    endtask
    initial begin
        void'($urandom(32'h751d_4a99));
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        rd_all();
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 4; i++) begin
                wr(i, r == 0 ? 8'hff : 8'($urandom));
            end
            drive(1, 0, 8'he9, 8'($urandom), 8'h00, 4'h0);
            rd_all();
        end
        for (int i = 0; i < 4; i++) begin
            wr(i, 8'($urandom));
            drive(0, 1, 8'he5 + i[7:0], 8'h00, 8'h00, 4'h0);
            put(0, shadow[i]);
        end
        for (int s = 0; s < 4; s++) begin
            drive(0, 0, 8'h00, 8'h00, 8'h00, 4'h0);
            sleep_state_select <= sleep_state_t'(s);
            s45_input_mask <= 8'($urandom);
            for (int j = 0; j < 8; j++) begin
                wr(j % 4, 8'($urandom));
                ev(8'($urandom), 4'($urandom));
            end
        end
        repeat (4) drive(0, 0, 8'h00, 8'h00, 8'h00, 4'h0);
        rst <= 1'b1;
        drive(0, 0, 8'h00, 8'h00, 8'hff, 4'hf);
        put(1, 8'h00);
        put(2, 8'h00);
        drive(0, 0, 8'h00, 8'h00, 8'h00, 4'h0);
        rst <= 1'b0;
        shadow = '{8'hff, 8'h0f, 8'hff, 8'h0f};
        rd_all();
        repeat (3) drive(0, 0, 8'h00, 8'h00, 8'h00, 4'h0);
        final_report();
    end
endmodule
`default_nettype wire
